// ---- rsx_top.sv ----
// Receive signaling substitution and extraction for 32 timeslots
// Functional notes
// - Substitution code in control bits 3:2
// - Code 00 forces all signaling bits one
// - 16-code uses substitution value bits 3-0
// - 4-code replaces A,B from bits 4-5
// - 2-code replaces A from bit 6
// - Extraction code in control bits 1:0
// - Extraction code 00 extracts nothing
// - Extraction code 01 extracts A,B,C,D
// - Extraction code 10 extracts A,B only
// - Extraction code 11 extracts A only
// - Extracted bits to array, pin, overhead
// - Substitution only while substitution enable set
// - Substitution affects PCM output only
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module rsx_top (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [rsx_pkg::RSX_ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Received signaling per timeslot
    input wire logic rx_sig_valid_i,
    output logic rx_sig_ready_o,
    input wire rsx_pkg::rsx_sig_t rx_sig_i,
    // Signaling toward the receive serial PCM output
    output logic pcm_sig_valid_o,
    input wire logic pcm_sig_ready_i,
    output rsx_pkg::rsx_sig_t pcm_sig_o,
    // Signaling output pin and overhead output
    output logic sig_pin_valid_o,
    output rsx_pkg::rsx_sig_t sig_pin_o,
    output logic oh_valid_o,
    output rsx_pkg::rsx_sig_t oh_o
);

    // ==========================================================
    // Helpers
    function automatic logic [3:0] ext_mask(input logic [1:0] code);
        case (code)
            rsx_pkg::RSX_CODE_ABCD: ext_mask = rsx_pkg::RSX_MASK_ABCD;
            rsx_pkg::RSX_CODE_AB: ext_mask = rsx_pkg::RSX_MASK_AB;
            rsx_pkg::RSX_CODE_A: ext_mask = rsx_pkg::RSX_MASK_A;
            default: ext_mask = rsx_pkg::RSX_MASK_NONE;
        endcase
    endfunction

    function automatic logic [3:0] subst(input logic [1:0] code, input logic [7:0] v,
                                         input logic [3:0] rx);
        logic [3:0] n;
        n = rx;
        case (code)
            rsx_pkg::RSX_CODE_ALT0: n = rsx_pkg::RSX_NIB_ONES;
            rsx_pkg::RSX_CODE_ABCD: begin
                n[rsx_pkg::RSX_A] = v[rsx_pkg::RSX_S16_LSB];
                n[rsx_pkg::RSX_B] = v[rsx_pkg::RSX_S16_LSB+1];
                n[rsx_pkg::RSX_C] = v[rsx_pkg::RSX_S16_LSB+2];
                n[rsx_pkg::RSX_D] = v[rsx_pkg::RSX_S16_LSB+3];
            end
            rsx_pkg::RSX_CODE_AB: begin
                n[rsx_pkg::RSX_A] = v[rsx_pkg::RSX_S4A_BIT];
                n[rsx_pkg::RSX_B] = v[rsx_pkg::RSX_S4B_BIT];
            end
            default: n[rsx_pkg::RSX_A] = v[rsx_pkg::RSX_S2A_BIT];
        endcase
        subst = n;
    endfunction

    // ==========================================================
    // Register storage
    logic [7:0] ctrl_r [rsx_pkg::RSX_TS_NUM];
    logic [7:0] subv_r [rsx_pkg::RSX_TS_NUM];
    logic [3:0] arr_r [rsx_pkg::RSX_TS_NUM];
    logic sigif_en_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;

    // ==========================================================
    // Bus decode
    wire wb_req = cyc_i & stb_i & ~ack_r;
    wire [1:0] wb_bank = adr_i[rsx_pkg::RSX_ADR_W-1:rsx_pkg::RSX_ADR_W-2];
    wire [rsx_pkg::RSX_TS_W-1:0] wb_ts = adr_i[rsx_pkg::RSX_ADR_W-3:2];
    // Writes commit on the ack edge, where the master completes the cycle
    wire wr_lane0 = cyc_i & stb_i & ack_r & we_i & sel_i[0];
    wire wr_ctrl = wr_lane0 & (wb_bank == rsx_pkg::RSX_BANK_CTRL);
    wire wr_subv = wr_lane0 & (wb_bank == rsx_pkg::RSX_BANK_SUBV);
    wire hit_glob = (wb_bank == rsx_pkg::RSX_BANK_GLOB) & (wb_ts == rsx_pkg::RSX_GLOB_TS);
    wire wr_glob = wr_lane0 & hit_glob;

    assign ack_o = ack_r;
    assign dat_o = dat_r;

    always_comb begin
        dat_nxt = rsx_pkg::RSX_RD_ZERO;
        case (wb_bank)
            rsx_pkg::RSX_BANK_CTRL: dat_nxt[7:0] = ctrl_r[wb_ts];
            rsx_pkg::RSX_BANK_SUBV: dat_nxt[7:0] = subv_r[wb_ts];
            rsx_pkg::RSX_BANK_ARR: dat_nxt[3:0] = arr_r[wb_ts];
            default: dat_nxt[rsx_pkg::RSX_GLOB_SIGIF_BIT] = hit_glob & sigif_en_r;
        endcase
    end

    // Every access gets ack one cycle later; unmapped words read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= rsx_pkg::RSX_RD_ZERO;
        end else begin
            ack_r <= wb_req;
            dat_r <= (wb_req & ~we_i) ? dat_nxt : rsx_pkg::RSX_RD_ZERO;
        end
    end

    // ==========================================================
    // Stream path
    wire fifo_in_ready;
    wire take = rx_sig_valid_i & fifo_in_ready;
    wire [rsx_pkg::RSX_TS_W-1:0] rx_ts = rx_sig_i.ts;
    wire [7:0] cur_ctrl = ctrl_r[rx_ts];
    wire [1:0] cur_subc = cur_ctrl[rsx_pkg::RSX_SUBC_LSB +: 2];
    wire [1:0] cur_ext = cur_ctrl[rsx_pkg::RSX_EXT_LSB +: 2];
    wire cur_suben = cur_ctrl[rsx_pkg::RSX_SUBEN_BIT];
    wire cur_ohen = cur_ctrl[rsx_pkg::RSX_OH_BIT];
    wire [3:0] cur_mask = ext_mask(cur_ext);
    wire [3:0] arr_merged = (arr_r[rx_ts] & ~cur_mask) | (rx_sig_i.abcd & cur_mask);
    rsx_pkg::rsx_sig_t pcm_in;

    assign pcm_in = {rx_ts, cur_suben ? subst(cur_subc, subv_r[rx_ts], rx_sig_i.abcd)
                                      : rx_sig_i.abcd};
    // Back-pressure from the PCM side stalls the receive stream
    assign rx_sig_ready_o = fifo_in_ready;

    rsx_fifo #(
        .WIDTH($bits(rsx_pkg::rsx_sig_t)),
        .DEPTH(rsx_pkg::RSX_FIFO_DEPTH)
    ) u_pcm_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(rx_sig_valid_i),
        .in_ready_o(fifo_in_ready),
        .in_data_i(pcm_in),
        .out_valid_o(pcm_sig_valid_o),
        .out_ready_i(pcm_sig_ready_i),
        .out_data_o(pcm_sig_o)
    );

    // ==========================================================
    // Register file updates
    // control fields written by software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < rsx_pkg::RSX_TS_NUM; i++) begin
                ctrl_r[i] <= rsx_pkg::RSX_CTRL_RST;
                subv_r[i] <= rsx_pkg::RSX_SUBV_RST;
            end
            sigif_en_r <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r[wb_ts] <= dat_i[7:0] & rsx_pkg::RSX_CTRL_MASK;
            end
            if (wr_subv) begin
                subv_r[wb_ts] <= dat_i[7:0] & rsx_pkg::RSX_SUBV_MASK;
            end
            if (wr_glob) begin
                sigif_en_r <= dat_i[rsx_pkg::RSX_GLOB_SIGIF_BIT];
            end
        end
    end

    // array holds received bits, never substituted
    // array always updated with extracted bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < rsx_pkg::RSX_TS_NUM; i++) begin
                arr_r[i] <= rsx_pkg::RSX_ARR_RST;
            end
        end else if (take) begin
            arr_r[rx_ts] <= arr_merged;
        end
    end

    // ==========================================================
    // Pin and overhead outputs
    logic sig_pin_valid_r;
    logic oh_valid_r;
    rsx_pkg::rsx_sig_t sig_pin_r;
    rsx_pkg::rsx_sig_t oh_r;
    wire extracted = take & (cur_mask != rsx_pkg::RSX_MASK_NONE);

    // pin and overhead gated by enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sig_pin_valid_r <= 1'b0;
            oh_valid_r <= 1'b0;
            sig_pin_r <= '0;
            oh_r <= '0;
        end else begin
            sig_pin_valid_r <= extracted & sigif_en_r;
            oh_valid_r <= extracted & cur_ohen;
            if (extracted) begin
                sig_pin_r <= {rx_ts, arr_merged};
                oh_r <= {rx_ts, arr_merged};
            end
        end
    end

    assign sig_pin_valid_o = sig_pin_valid_r;
    assign sig_pin_o = sig_pin_r;
    assign oh_valid_o = oh_valid_r;
    assign oh_o = oh_r;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence take_pin_s(logic [1:0] e);
        take && cur_ext == e && sigif_en_r;
    endsequence

    sequence take_sub_s(logic [1:0] c);
        take && cur_suben && cur_subc == c;
    endsequence

    ctrl_write_a: assert property (wr_ctrl |=> ctrl_r[$past(wb_ts)] ==
        ($past(dat_i[7:0]) & rsx_pkg::RSX_CTRL_MASK))
        else $error("control register write lost");

    subst_ones_a: assert property (take_sub_s(rsx_pkg::RSX_CODE_ALT0) |->
        pcm_in.abcd == rsx_pkg::RSX_NIB_ONES)
        else $error("code 00 did not force ones");

    subst_sixteen_a: assert property (take_sub_s(rsx_pkg::RSX_CODE_ABCD) |->
        pcm_in.abcd == {subv_r[rx_ts][rsx_pkg::RSX_S16_LSB],
            subv_r[rx_ts][rsx_pkg::RSX_S16_LSB+1], subv_r[rx_ts][rsx_pkg::RSX_S16_LSB+2],
            subv_r[rx_ts][rsx_pkg::RSX_S16_LSB+3]})
        else $error("16-code substitution wrong");

    subst_four_a: assert property (take_sub_s(rsx_pkg::RSX_CODE_AB) |->
        pcm_in.abcd[1:0] == rx_sig_i.abcd[1:0]
        && pcm_in.abcd[rsx_pkg::RSX_A] == subv_r[rx_ts][rsx_pkg::RSX_S4A_BIT]
        && pcm_in.abcd[rsx_pkg::RSX_B] == subv_r[rx_ts][rsx_pkg::RSX_S4B_BIT])
        else $error("4-code substitution wrong");

    subst_two_a: assert property (take_sub_s(rsx_pkg::RSX_CODE_A) |->
        pcm_in.abcd[2:0] == rx_sig_i.abcd[2:0]
        && pcm_in.abcd[rsx_pkg::RSX_A] == subv_r[rx_ts][rsx_pkg::RSX_S2A_BIT])
        else $error("2-code substitution wrong");

    subst_off_a: assert property (take && !cur_suben |->
        pcm_in.abcd == rx_sig_i.abcd)
        else $error("substitution applied while disabled");

    ext_none_a: assert property (take && cur_ext == rsx_pkg::RSX_CODE_ALT0 |=>
        !sig_pin_valid_o && !oh_valid_o)
        else $error("extraction occurred for code 00");

    ext_full_a: assert property (take_pin_s(rsx_pkg::RSX_CODE_ABCD) |=>
        sig_pin_valid_o && sig_pin_o.abcd == $past(rx_sig_i.abcd))
        else $error("ABCD extraction wrong");

    ext_ab_a: assert property (take_pin_s(rsx_pkg::RSX_CODE_AB) |=>
        sig_pin_valid_o && sig_pin_o.abcd[3:2] == $past(rx_sig_i.abcd[3:2]))
        else $error("AB extraction wrong");

    ext_a_only_a: assert property (take_pin_s(rsx_pkg::RSX_CODE_A) |=>
        sig_pin_valid_o && sig_pin_o.abcd[rsx_pkg::RSX_A] == $past(rx_sig_i.abcd[3]))
        else $error("A extraction wrong");

    oh_gate_a: assert property (extracted && !cur_ohen |=> !oh_valid_o)
        else $error("overhead output while disabled");

    arr_raw_a: assert property (take && cur_suben
        && cur_ext == rsx_pkg::RSX_CODE_ABCD |=> arr_r[$past(rx_ts)] == $past(rx_sig_i.abcd))
        else $error("array took substituted value");

    bus_ack_a: assert property (wb_req |=> ack_o ##1 !ack_o)
        else $error("bus ack not a single cycle pulse");

endmodule

// ---- rsx_pkg.sv ----
// Shared constants and carriers for the receive signaling substitute/extract block
package rsx_pkg;

    // ==========================================================
    // Geometry
    localparam int RSX_TS_NUM = 32;
    localparam int RSX_TS_W = 5;
    localparam int RSX_ADR_W = 9;
    localparam int RSX_FIFO_DEPTH = 4;

    // ==========================================================
    // Register map: word index = {bank, timeslot}
    localparam logic [1:0] RSX_BANK_CTRL = 2'h0;
    localparam logic [1:0] RSX_BANK_SUBV = 2'h1;
    localparam logic [1:0] RSX_BANK_ARR = 2'h2;
    localparam logic [1:0] RSX_BANK_GLOB = 2'h3;
    localparam logic [4:0] RSX_GLOB_TS = 5'h00;
    localparam logic [7:0] RSX_CTRL_RST = 8'h00;
    localparam logic [7:0] RSX_SUBV_RST = 8'h00;
    localparam logic [3:0] RSX_ARR_RST = 4'h0;
    localparam logic [7:0] RSX_CTRL_MASK = 8'h7f;
    localparam logic [7:0] RSX_SUBV_MASK = 8'h7f;
    localparam logic [31:0] RSX_RD_ZERO = 32'h0000_0000;

    // ==========================================================
    // Control register fields
    localparam int RSX_EXT_LSB = 0;
    localparam int RSX_SUBC_LSB = 2;
    localparam int RSX_DEB_BIT = 4;
    localparam int RSX_OH_BIT = 5;
    localparam int RSX_SUBEN_BIT = 6;
    localparam int RSX_GLOB_SIGIF_BIT = 0;

    // Substitution value register fields
    localparam int RSX_S16_LSB = 0;
    localparam int RSX_S4A_BIT = 4;
    localparam int RSX_S4B_BIT = 5;
    localparam int RSX_S2A_BIT = 6;

    // Position of A..D inside a signaling nibble
    localparam int RSX_A = 3;
    localparam int RSX_B = 2;
    localparam int RSX_C = 1;
    localparam int RSX_D = 0;

    // ==========================================================
    // Scheme codes
    localparam logic [1:0] RSX_CODE_ALT0 = 2'h0;
    localparam logic [1:0] RSX_CODE_ABCD = 2'h1;
    localparam logic [1:0] RSX_CODE_AB = 2'h2;
    localparam logic [1:0] RSX_CODE_A = 2'h3;
    localparam logic [3:0] RSX_NIB_ONES = 4'hf;
    localparam logic [3:0] RSX_MASK_NONE = 4'h0;
    localparam logic [3:0] RSX_MASK_ABCD = 4'hf;
    localparam logic [3:0] RSX_MASK_AB = 4'hc;
    localparam logic [3:0] RSX_MASK_A = 4'h8;

    typedef struct packed {
        logic [RSX_TS_W-1:0] ts;
        logic [3:0] abcd;
    } rsx_sig_t;

endpackage

// ---- rsx_fifo.sv ----
// Small flop-based FIFO with valid/ready on both sides
`timescale 1ns/1ps
module rsx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;

    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;

    assign in_ready_o = (count_r != (AW+1)'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign out_data_o = mem_r[rd_ptr_r];

    // Pointer wrap relies on DEPTH being a power of two
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end
endmodule

// ---- rsx_pcm_sink.sv ----
// Model of the PCM-side consumer of substituted signaling words
`timescale 1ns/1ps
module rsx_pcm_sink (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic stall_i,
    input wire logic slow_i,
    input wire logic valid_i,
    input wire rsx_pkg::rsx_sig_t data_i,
    output logic ready_o
);
    // ==========================================================
    // Accept logic
    rsx_pkg::rsx_sig_t got[$];
    logic phase_r;

    // Slow mode accepts every other cycle only, to exercise back-pressure
    assign ready_o = !stall_i && (!slow_i || phase_r);

    // Plain always: the bench pops this queue as well
    always @(posedge clk_i) begin
        if (rst_i) begin
            phase_r <= 1'b0;
        end else begin
            phase_r <= !phase_r;
            if (valid_i && ready_o) begin
                got.push_back(data_i);
            end
        end
    end
endmodule

// ---- rx_signaling_substitute_extract_tb_top.sv ----
// Self-checking bench for the receive signaling substitute/extract block
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; $display("unexpected t=%0t got %h exp %h", $time, (g), (e)); end end
module rx_signaling_substitute_extract_tb_top;
    // ==========================================================
    // Signals and reference state
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [8:0] adr_i = 9'h000;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic rx_sig_valid_i = 1'b0;
    logic rx_sig_ready_o;
    rsx_pkg::rsx_sig_t rx_sig_i = '0;
    rsx_pkg::rsx_sig_t pcm_sig_o, sig_pin_o, oh_o;
    logic pcm_sig_valid_o, pcm_sig_ready_i, sig_pin_valid_o, oh_valid_o;
    logic stall = 1'b0;
    logic slow = 1'b0;
    int mismatches = 0;
    int n_compared = 0;
    integer seed = 32'hb26b;
    logic [7:0] m_ctrl[32] = '{default: 8'h00};
    logic [7:0] m_subv[32] = '{default: 8'h00};
    logic [3:0] m_arr[32] = '{default: 4'h0};
    logic m_glob = 1'b0;
    rsx_pkg::rsx_sig_t exp_q[$];

    always #2.5 clk_i = ~clk_i;

    rsx_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .rx_sig_valid_i(rx_sig_valid_i), .rx_sig_ready_o(rx_sig_ready_o), .rx_sig_i(rx_sig_i),
        .pcm_sig_valid_o(pcm_sig_valid_o), .pcm_sig_ready_i(pcm_sig_ready_i),
        .pcm_sig_o(pcm_sig_o), .sig_pin_valid_o(sig_pin_valid_o), .sig_pin_o(sig_pin_o),
        .oh_valid_o(oh_valid_o), .oh_o(oh_o));

    rsx_pcm_sink sink (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .slow_i(slow),
        .valid_i(pcm_sig_valid_o), .data_i(pcm_sig_o), .ready_o(pcm_sig_ready_i));

    // ==========================================================
    // Reference model
    // substitution
    function automatic logic [3:0] sub_exp(logic [7:0] c, logic [7:0] s, logic [3:0] rx);
        if (!c[6]) return rx;
        case (c[3:2])
            2'h0: return 4'hf;
            2'h1: return {s[0], s[1], s[2], s[3]};
            2'h2: return {s[4], s[5], rx[1:0]};
            default: return {s[6], rx[2:0]};
        endcase
    endfunction

    function automatic logic [3:0] ext_mask(logic [1:0] e);
        case (e)
            2'h0: return 4'h0;
            2'h1: return 4'hf;
            2'h2: return 4'hc;
            default: return 4'h8;
        endcase
    endfunction

    // ==========================================================
    // Bus and stream tasks
    task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'h1;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic send(input logic [4:0] ts, input logic [3:0] rx);
        logic [3:0] m;
        logic [3:0] nib;
        m = ext_mask(m_ctrl[ts][1:0]);
        nib = (m_arr[ts] & ~m) | (rx & m);
        exp_q.push_back({ts, sub_exp(m_ctrl[ts], m_subv[ts], rx)});
        rx_sig_valid_i <= 1'b1;
        rx_sig_i <= {ts, rx};
        do @(posedge clk_i); while (rx_sig_ready_o !== 1'b1);
        rx_sig_valid_i <= 1'b0;
        m_arr[ts] = nib;
        @(posedge clk_i);
        `CHK(sig_pin_valid_o, m_glob && m != 4'h0)
        if (m != 4'h0) begin
            `CHK(oh_valid_o, m_ctrl[ts][5])
            if (m_glob) `CHK(sig_pin_o, {ts, nib})
            if (m_ctrl[ts][5]) `CHK(oh_o, {ts, nib})
        end
    endtask

    task automatic drain_chk();
        rsx_pkg::rsx_sig_t g;
        rsx_pkg::rsx_sig_t e;
        while (sink.got.size() < exp_q.size()) @(posedge clk_i);
        while (exp_q.size() > 0) begin
            g = sink.got.pop_front();
            e = exp_q.pop_front();
            `CHK(g, e)
        end
    endtask

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] q;
        logic [4:0] ts;
        logic [7:0] c;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int t = 0; t < 32; t++) begin
            for (int b = 0; b < 3; b++) begin
                wb(1'b0, {2'(b), 5'(t), 2'b00}, 32'h0, q);
                `CHK(q, 32'h0)
            end
        end
        wb(1'b0, 9'h184, 32'h0, q);
        `CHK(q, 32'h0)
        // First 16 passes walk every code pair with substitution on
        for (int i = 0; i < 48; i++) begin
            ts = 5'($random(seed));
            c = 8'($random(seed)) & rsx_pkg::RSX_CTRL_MASK;
            if (i < 16) c[3:0] = i[3:0];
            if (i < 16) c[6] = 1'b1;
            m_ctrl[ts] = c;
            m_subv[ts] = 8'($random(seed)) & rsx_pkg::RSX_SUBV_MASK;
            m_glob = i[1];
            slow <= i[2];
            wb(1'b1, {rsx_pkg::RSX_BANK_GLOB, rsx_pkg::RSX_GLOB_TS, 2'b00}, {31'h0, m_glob}, q);
            wb(1'b1, {rsx_pkg::RSX_BANK_CTRL, ts, 2'b00}, {24'h0, c}, q);
            wb(1'b1, {rsx_pkg::RSX_BANK_SUBV, ts, 2'b00}, {24'h0, m_subv[ts]}, q);
            wb(1'b0, {rsx_pkg::RSX_BANK_CTRL, ts, 2'b00}, 32'h0, q);
            `CHK(q, {24'h0, c})
            send(ts, 4'($random(seed)));
            wb(1'b0, {rsx_pkg::RSX_BANK_ARR, ts, 2'b00}, 32'h0, q);
            `CHK(q, {28'h0, m_arr[ts]})
            drain_chk();
        end
        // Stalled sink: buffer must refuse once full
        stall <= 1'b1;
        for (int k = 0; k < rsx_pkg::RSX_FIFO_DEPTH; k++) send(5'(k), 4'(k + 5));
        `CHK(rx_sig_ready_o, 1'b0)
        stall <= 1'b0;
        drain_chk();
        close_out();
    end

    initial begin
        #100us;
        mismatches++;
        close_out();
    end
endmodule
